// File: src/nfc_host.sv
// host-side command sequencer driving a banked nor flash over its pins
//==========================================================
// Overview of operation
// - bad sequence leaves flash undefined; host recovers by writing reset
// - on timeout flag host writes reset; ready/busy stays low until then
// - identification: two unlocks then bank address with ident command
// - host issues identification only to an idle or suspended bank
// - identification left by reset; reset allowed between its cycles
// - three-cycle entry to secured region, four-cycle exit
// - program is two unlocks, set-up command, then address and data
// - bypass entered by unlocks plus 20h; program is A0h then data
// - bypass accepts only bypass program and two-cycle bypass reset; host also lets reset F0h through in bypass
// - erase suspend B0h written with a bank address
`timescale 1ns/1ps
`default_nettype none
`include "nfc_regs.svh"

module nfc_host
    import nfc_pkg::*;
#(
    parameter logic [21:0] UNLOCK_A1 = `NFC_UNLOCK_A1,
    parameter logic [15:0] UNLOCK_D1 = `NFC_UNLOCK_D1,
    parameter logic [21:0] UNLOCK_A2 = `NFC_UNLOCK_A2,
    parameter logic [15:0] UNLOCK_D2 = `NFC_UNLOCK_D2
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // software port
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // flash pins
    output logic [21:0] FL_ADDR_O,
    output logic [15:0] FL_DQ_O,
    output logic FL_DQ_OE_N_O,
    input wire logic [15:0] FL_DQ_I,
    output logic FL_CE_N_O,
    output logic FL_WE_N_O,
    output logic FL_OE_N_O,
    output logic FL_BYTE_N_O,
    output logic FL_ACC_O,
    output logic FL_RESET_N_O,
    input wire logic FL_RY_I
);
    // ==========================================================
    // state
    nfc_state_type state_q, state_d;
    nfc_op_type op_q;
    nfc_cycle_type cyc_q;
    nfc_cycle_type seq_q [0:5];
    nfc_strobe_type stb_q;
    logic [2:0] nseq_q, idx_q;
    logic [4:0] cnt_q;
    logic [21:0] addr_q;
    logic [15:0] wdata_q, rdata_q;
    logic [1:0] ctrl_q;
    logic dq_oe_n_q, busy_q, bypass_q, secured_q, ident_q, err_q, timeout_q;
    logic rst_n_q;
    logic [15:0] dq_m_q, dq_s_q;
    logic ry_m_q, ry_s_q;
    logic [31:0] rdata_o_q;

    // ==========================================================
    // software decode
    wire wr_cmd = WR_I && ADDR_I == `NFC_REG_CMD;
    wire [3:0] op_code = WDATA_I[3:0];
    // polling bit equal to data written means the embedded program finished
    wire poll_done = dq_s_q[7] == wdata_q[7];
    wire timeout_seen = dq_s_q[5] && !poll_done;
    wire idle = state_q == ST_IDLE;
    wire last_cyc = idx_q == nseq_q - 3'd1;
    // each setup presents the word of the cycle under way, not always the first one
    wire [2:0] word_sel = state_q == ST_HOLD ? idx_q + 3'h1 : state_q == ST_SETUP ? idx_q : 3'h0;
    // status on the pins is only trusted once read access time and the synchroniser have passed
    wire wait_live = state_q == ST_WAIT && cnt_q == 5'h0;
    // commands written while busy are dropped silently; only mode refusals are errors
    wire refused = wr_cmd && idle && !op_ok;
    // when idle, bypass mode fences off all but bypass program, bypass exit and reset; secured mode fences off only bypass entry
    wire op_ok = idle && !(bypass_q && op_code != OP_BYP_PROG && op_code != OP_BYP_EXIT
                 && op_code != OP_RESET) && !(secured_q && (op_code == OP_BYP_ENTER));

    function automatic nfc_cycle_type mk(input logic [21:0] a, input logic [15:0] d);
        mk.addr = a;
        mk.data = d;
    endfunction

    function automatic logic [4:0] cyc5(input int n);
        cyc5 = n[4:0];
    endfunction

    // ==========================================================
    // sequence builder
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            nseq_q <= 3'h0;
            op_q <= OP_READ;
            for (int i = 0; i < 6; i++) seq_q[i] <= '0;
        end else if (wr_cmd && op_ok) begin
            op_q <= nfc_op_type'(op_code);
            seq_q[0] <= mk(UNLOCK_A1, UNLOCK_D1);
            seq_q[1] <= mk(UNLOCK_A2, UNLOCK_D2);
            case (op_code)
                OP_READ: begin
                    seq_q[0] <= mk(addr_q, 16'h0000);
                    nseq_q <= 3'h1;
                end
                OP_RESET: begin
                    seq_q[0] <= mk(22'h000000, `NFC_CD_RESET);
                    nseq_q <= 3'h1;
                end
                OP_IDENT: begin
                    seq_q[2] <= mk({addr_q[21:12], UNLOCK_A1[11:0]}, `NFC_CD_IDENT);
                    nseq_q <= 3'h3;
                end
                OP_SEC_ENTER: begin
                    seq_q[2] <= mk(UNLOCK_A1, `NFC_CD_SEC_IN);
                    nseq_q <= 3'h3;
                end
                OP_SEC_EXIT: begin
                    seq_q[2] <= mk(UNLOCK_A1, `NFC_CD_SEC_OUT1);
                    seq_q[3] <= mk(22'h000000, `NFC_CD_SEC_OUT2);
                    nseq_q <= 3'h4;
                end
                OP_PROGRAM: begin
                    seq_q[2] <= mk(UNLOCK_A1, `NFC_CD_PROG);
                    seq_q[3] <= mk(addr_q, wdata_q);
                    nseq_q <= 3'h4;
                end
                OP_BYP_ENTER: begin
                    seq_q[2] <= mk(UNLOCK_A1, `NFC_CD_BYPASS);
                    nseq_q <= 3'h3;
                end
                OP_BYP_PROG: begin
                    seq_q[0] <= mk(22'h000000, `NFC_CD_PROG);
                    seq_q[1] <= mk(addr_q, wdata_q);
                    nseq_q <= 3'h2;
                end
                OP_BYP_EXIT: begin
                    seq_q[0] <= mk(22'h000000, `NFC_CD_BYP_RST1);
                    seq_q[1] <= mk(22'h000000, `NFC_CD_BYP_RST2);
                    nseq_q <= 3'h2;
                end
                OP_SUSPEND: begin
                    seq_q[0] <= mk(addr_q, `NFC_CD_SUSPEND);
                    nseq_q <= 3'h1;
                end
                default: begin
                    nseq_q <= 3'h0;
                end
            endcase
        end
    end

    // ==========================================================
    // bus cycle machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (wr_cmd && op_ok && op_code <= OP_SUSPEND) state_d = ST_SETUP;
            ST_SETUP: if (cnt_q == 5'h0) state_d = op_q == OP_READ ? ST_READ : ST_PULSE;
            ST_PULSE: if (cnt_q == 5'h0) state_d = ST_HOLD;
            ST_HOLD: if (cnt_q == 5'h0) begin
                if (!last_cyc) state_d = ST_SETUP;
                else if (op_q == OP_PROGRAM || op_q == OP_BYP_PROG) state_d = ST_WAIT;
                else state_d = ST_IDLE;
            end
            ST_READ: if (cnt_q == 5'h0) state_d = ST_IDLE;
            // leaves on completion or on the timeout flag, so that software can send its reset
            ST_WAIT: if (cnt_q == 5'h0 && ((ry_s_q && poll_done) || timeout_seen)) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h0;
            idx_q <= 3'h0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                case (state_d)
                    ST_SETUP: cnt_q <= cyc5(`NFC_SETUP_CYC - 1);
                    ST_PULSE: cnt_q <= cyc5(`NFC_PULSE_CYC - 1);
                    ST_HOLD: cnt_q <= cyc5(`NFC_HOLD_CYC - 1);
                    ST_READ: cnt_q <= cyc5(`NFC_RDACC_CYC - 1);
                    ST_WAIT: cnt_q <= cyc5(`NFC_RDACC_CYC + 2);
                    default: cnt_q <= 5'h0;
                endcase
            end else if (cnt_q != 5'h0) begin
                cnt_q <= cnt_q - 5'h1;
            end
            if (state_q == ST_IDLE) idx_q <= 3'h0;
            else if (state_q == ST_HOLD && cnt_q == 5'h0) idx_q <= idx_q + 3'h1;
        end
    end

    // ==========================================================
    // pins: ce falls at setup and we falls after it, so address is taken at the we fall
    // and data at the we rise, with ce still low through hold
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            stb_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, byte_n: 1'b1, acc_high: 1'b0};
            cyc_q <= '0;
            dq_oe_n_q <= 1'b1;
            rst_n_q <= 1'b0;
        end else begin
            rst_n_q <= 1'b1;
            stb_q.byte_n <= !ctrl_q[`NFC_CT_BYTE];
            stb_q.acc_high <= ctrl_q[`NFC_CT_ACCEL] && !secured_q;
            stb_q.ce_n <= !(state_d != ST_IDLE && state_d != ST_WAIT) && state_d != ST_WAIT;
            stb_q.we_n <= state_d != ST_PULSE;
            stb_q.oe_n <= !(state_d == ST_READ || state_d == ST_WAIT);
            dq_oe_n_q <= !(state_d == ST_SETUP || state_d == ST_PULSE || state_d == ST_HOLD)
                         || op_q == OP_READ;
            if (state_d == ST_SETUP) cyc_q <= seq_q[word_sel];
        end
    end

    // ==========================================================
    // pin input synchronisers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            dq_m_q <= 16'h0000;
            dq_s_q <= 16'h0000;
            ry_m_q <= 1'b1;
            ry_s_q <= 1'b1;
        end else begin
            dq_m_q <= FL_DQ_I;
            dq_s_q <= dq_m_q;
            ry_m_q <= FL_RY_I;
            ry_s_q <= ry_m_q;
        end
    end

    // ==========================================================
    // mode tracking and software registers
    wire seq_end = state_q == ST_HOLD && cnt_q == 5'h0 && last_cyc;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            addr_q <= 22'h0;
            wdata_q <= 16'h0;
            ctrl_q <= 2'h0;
            rdata_q <= 16'h0;
            busy_q <= 1'b0;
            bypass_q <= 1'b0;
            secured_q <= 1'b0;
            ident_q <= 1'b0;
            err_q <= 1'b0;
            timeout_q <= 1'b0;
        end else begin
            if (WR_I && ADDR_I == `NFC_REG_ADDR) addr_q <= WDATA_I[21:0];
            if (WR_I && ADDR_I == `NFC_REG_WDATA) wdata_q <= WDATA_I[15:0];
            if (WR_I && ADDR_I == `NFC_REG_CTRL) ctrl_q <= WDATA_I[1:0];
            busy_q <= state_d != ST_IDLE;
            if (state_q == ST_READ && cnt_q == 5'h0) rdata_q <= dq_s_q;
            // a refused command marks the flash state unknown until reset is sent
            if (refused) err_q <= 1'b1;
            else if (seq_end && op_q == OP_RESET) err_q <= 1'b0;
            if (wait_live && timeout_seen) timeout_q <= 1'b1;
            else if (seq_end && op_q == OP_RESET) timeout_q <= 1'b0;
            if (seq_end) begin
                case (op_q)
                    OP_IDENT: ident_q <= 1'b1;
                    OP_RESET: ident_q <= 1'b0;
                    OP_SEC_ENTER: secured_q <= 1'b1;
                    OP_SEC_EXIT: secured_q <= 1'b0;
                    OP_BYP_ENTER: bypass_q <= 1'b1;
                    OP_BYP_EXIT: bypass_q <= 1'b0;
                    default: ;
                endcase
            end
            // a timed out program is abandoned as soon as the timeout flag is seen, before its reset is issued
            if (wait_live && timeout_seen) busy_q <= 1'b0;
        end
    end

    // ==========================================================
    // read port
    wire [31:0] status_w = {25'h0, err_q, ident_q, secured_q, bypass_q, timeout_q, ry_s_q, busy_q};
    wire [31:0] rd_mux = ADDR_I == `NFC_REG_STATUS ? status_w :
                         ADDR_I == `NFC_REG_RDATA ? {16'h0, rdata_q} :
                         ADDR_I == `NFC_REG_ADDR ? {10'h0, addr_q} :
                         ADDR_I == `NFC_REG_WDATA ? {16'h0, wdata_q} :
                         ADDR_I == `NFC_REG_CTRL ? {30'h0, ctrl_q} : 32'h0;
    always_ff @(posedge CLK_I) begin
        if (RST_I) rdata_o_q <= 32'h0;
        else rdata_o_q <= RD_I ? rd_mux : 32'h0;
    end

    assign RDATA_O = rdata_o_q;
    assign FL_ADDR_O = cyc_q.addr;
    assign FL_DQ_O = cyc_q.data;
    assign FL_DQ_OE_N_O = dq_oe_n_q;
    assign FL_CE_N_O = stb_q.ce_n;
    assign FL_WE_N_O = stb_q.we_n;
    assign FL_OE_N_O = stb_q.oe_n;
    assign FL_BYTE_N_O = stb_q.byte_n;
    assign FL_ACC_O = stb_q.acc_high;
    assign FL_RESET_N_O = rst_n_q;
endmodule
`default_nettype wire

// File: src/nfc_pkg.sv
// types of the flash host controller
package nfc_pkg;
    typedef enum logic [3:0] {
        OP_READ      = 4'h0,
        OP_RESET     = 4'h1,
        OP_IDENT     = 4'h2,
        OP_SEC_ENTER = 4'h3,
        OP_SEC_EXIT  = 4'h4,
        OP_PROGRAM   = 4'h5,
        OP_BYP_ENTER = 4'h6,
        OP_BYP_PROG  = 4'h7,
        OP_BYP_EXIT  = 4'h8,
        OP_SUSPEND   = 4'h9
    } nfc_op_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_PULSE = 3'b010,
        ST_HOLD  = 3'b011,
        ST_READ  = 3'b100,
        ST_WAIT  = 3'b101
    } nfc_state_type;

    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] data;
    } nfc_cycle_type;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic byte_n;
        logic acc_high;
    } nfc_strobe_type;
endpackage

// File: src/nfc_regs.svh
// register map, field positions and timing counts of the flash host controller
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH
// ==========================================================
// controller registers (word index on the software port)
`define NFC_REG_CMD      4'h0
`define NFC_REG_ADDR     4'h1
`define NFC_REG_WDATA    4'h2
`define NFC_REG_STATUS   4'h3
`define NFC_REG_RDATA    4'h4
`define NFC_REG_CTRL     4'h5
// ==========================================================
// status bit positions
`define NFC_ST_BUSY      0
`define NFC_ST_RDY_PIN   1
`define NFC_ST_TIMEOUT   2
`define NFC_ST_BYPASS    3
`define NFC_ST_SECURED   4
`define NFC_ST_IDENT     5
`define NFC_ST_ERR       6
// control bit positions
`define NFC_CT_BYTE      0
`define NFC_CT_ACCEL     1
// ==========================================================
// flash command codes and unlock pattern
`define NFC_UNLOCK_A1    22'h000555
`define NFC_UNLOCK_D1    16'h00aa
`define NFC_UNLOCK_A2    22'h0002aa
`define NFC_UNLOCK_D2    16'h0055
`define NFC_CD_RESET     16'h00f0
`define NFC_CD_IDENT     16'h0090
`define NFC_CD_PROG      16'h00a0
`define NFC_CD_BYPASS    16'h0020
`define NFC_CD_BYP_RST1  16'h0090
`define NFC_CD_BYP_RST2  16'h0000
`define NFC_CD_SEC_IN    16'h0088
`define NFC_CD_SEC_OUT1  16'h0090
`define NFC_CD_SEC_OUT2  16'h0000
`define NFC_CD_SUSPEND   16'h00b0
// ==========================================================
// bus cycle timing in ns and derived cycles at 200 MHz
`define NFC_CLK_NS       5
`define NFC_T_SETUP_NS   10
`define NFC_T_PULSE_NS   35
`define NFC_T_HOLD_NS    20
`define NFC_T_RDACC_NS   70
`define NFC_SETUP_CYC    ((`NFC_T_SETUP_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_PULSE_CYC    ((`NFC_T_PULSE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_HOLD_CYC     ((`NFC_T_HOLD_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_RDACC_CYC    ((`NFC_T_RDACC_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// File: verif/nfc_flash_mdl.sv
// behavioural nor flash answering the controller pins
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_mdl #(
    parameter int PROG_NS = 1000,
    parameter logic [15:0] IDENT_WORD = 16'h5a3c // arbitrary value
) (
    // strobes and address
    input wire logic [21:0] addr_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic acc_i,
    input wire logic reset_n_i,
    // data wire and ready
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic ry_o
);
    logic [15:0] mem [logic [22:0]];
    logic [21:0] a_q;
    logic [15:0] val_q;
    logic [15:0] pd_q;
    logic [2:0] step_q;
    logic ident_q, sec_q, byp_q, busy_q, tmo_q, tog_q, fail_q;
    wire wr_n = ce_n_i | we_n_i;
    wire rd_n = ce_n_i | oe_n_i;
    initial begin
        {step_q, ident_q, sec_q, byp_q, busy_q, tmo_q, tog_q, fail_q, val_q, pd_q} = '0;
        ry_o = 1'b1;
    end
    // hardware reset aborts everything, secured state kept
    always @(negedge reset_n_i) begin
        {step_q, ident_q, byp_q, busy_q, tmo_q} = '0;
        ry_o = 1'b1;
    end
    always @(negedge wr_n) a_q = addr_i;
    always @(posedge wr_n) if (reset_n_i === 1'b1) take(a_q, dq_i);
    task automatic take(input logic [21:0] a, input logic [15:0] d);
        logic [22:0] k;
        k = {sec_q, a};
        if (busy_q && !(tmo_q && d == 16'h00f0)) return;
        if (d == 16'h00f0 && !(byp_q || acc_i)) begin
            {step_q, ident_q, busy_q, tmo_q} = '0;
            ry_o = 1'b1;
        end else if ((byp_q || acc_i) && step_q == 3'd0) begin
            step_q = d == 16'h00a0 ? 3'd3 : d == 16'h0090 ? 3'd4 : 3'd0;
        end else case (step_q)
            3'd0: step_q = (a == 22'h000555 && d == 16'h00aa) ? 3'd1 : 3'd0;
            3'd1: step_q = (a == 22'h0002aa && d == 16'h0055) ? 3'd2 : 3'd0;
            3'd2: begin
                step_q = 3'd0;
                if (d == 16'h0090 && sec_q) step_q = 3'd4;
                else if (d == 16'h0090) ident_q = 1'b1;
                else if (d == 16'h0088) sec_q = 1'b1;
                else if (d == 16'h0020 && !sec_q) byp_q = 1'b1;
                else if (d == 16'h00a0) step_q = 3'd3;
            end
            3'd3: begin
                step_q = 3'd0;
                pd_q = d;
                mem[k] = (mem.exists(k) ? mem[k] : 16'hffff) & d;
                busy_q = 1'b1;
                ry_o = 1'b0;
                fork
                    begin
                        #(PROG_NS);
                        if (fail_q) tmo_q = 1'b1;
                        else {busy_q, ry_o} = 2'b01;
                        // a bus held in read follows the end of the operation
                        if (!rd_n) val_q = tmo_q ? {8'h00, ~pd_q[7], tog_q, 1'b1, 5'h00} : pd_q;
                    end
                join_none
            end
            default: begin
                if (d == 16'h0000 && byp_q) byp_q = 1'b0;
                else if (d == 16'h0000) sec_q = 1'b0;
                step_q = 3'd0;
            end
        endcase
    endtask
    // released bus shows the inverse so a stale sample is caught
    always @(negedge rd_n) begin
        tog_q = ~tog_q;
        #10;
        if (busy_q) val_q = {8'h00, ~pd_q[7], tog_q, tmo_q, 5'h00};
        else if (ident_q) val_q = IDENT_WORD;
        else val_q = mem.exists({sec_q, addr_i}) ? mem[{sec_q, addr_i}] : 16'hffff;
    end
    assign dq_o = rd_n ? ~val_q : val_q;
endmodule
`default_nettype wire

// File: verif/nfc_host_chk.sv
// pin-level assertion checker for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module nfc_host_chk (
    // clock, reset and software port
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    // flash pins
    input wire logic [21:0] FL_ADDR_O,
    input wire logic [15:0] FL_DQ_O,
    input wire logic FL_DQ_OE_N_O,
    input wire logic [15:0] FL_DQ_I,
    input wire logic FL_CE_N_O,
    input wire logic FL_WE_N_O,
    input wire logic FL_OE_N_O,
    input wire logic FL_BYTE_N_O,
    input wire logic FL_ACC_O,
    input wire logic FL_RESET_N_O,
    input wire logic FL_RY_I
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ==========================================================
    // write cycle shape
    chk_we_in_ce: assert property (!FL_WE_N_O |-> !FL_CE_N_O)
        else $error("write strobe low outside chip enable");
    chk_we_width: assert property ($fell(FL_WE_N_O) |-> !FL_WE_N_O [*7] ##1 FL_WE_N_O)
        else $error("write pulse not seven cycles");
    chk_we_setup: assert property ($fell(FL_WE_N_O) |-> !$past(FL_CE_N_O) && !FL_DQ_OE_N_O)
        else $error("write pulse without setup");
    chk_data_stable: assert property ($rose(FL_WE_N_O) |-> !FL_DQ_OE_N_O && $stable(FL_DQ_O) && $stable(FL_ADDR_O))
        else $error("data or address moved at latch edge");
    chk_we_hold: assert property ($rose(FL_WE_N_O) |-> FL_WE_N_O [*4])
        else $error("write hold too short");
    // ==========================================================
    // read cycle, pins and reset
    chk_no_contend: assert property (!FL_OE_N_O |-> FL_DQ_OE_N_O && FL_WE_N_O)
        else $error("data driven during read");
    chk_read_len: assert property ($fell(FL_OE_N_O) |-> (!FL_OE_N_O && !FL_CE_N_O) [*8])
        else $error("read strobe too short");
    chk_rdata_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
        else $error("read data outside read slot");
    chk_hw_reset: assert property ($fell(RST_I) |-> !FL_RESET_N_O ##1 FL_RESET_N_O)
        else $error("flash reset release wrong");
    chk_byte_pin: assert property (WR_I && ADDR_I == 4'h5 |-> ##2 FL_BYTE_N_O == !$past(WDATA_I[0], 2))
        else $error("width pin does not follow control");
    chk_acc_off: assert property (WR_I && ADDR_I == 4'h5 && !WDATA_I[1] |-> ##2 !FL_ACC_O)
        else $error("accelerate pin left high");
    cov_write: cover property ($fell(FL_WE_N_O));
    cov_read: cover property ($fell(FL_OE_N_O));
    cov_busy: cover property ($fell(FL_RY_I));
endmodule

bind nfc_host nfc_host_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .FL_ADDR_O(FL_ADDR_O), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_N_O(FL_DQ_OE_N_O),
    .FL_DQ_I(FL_DQ_I), .FL_CE_N_O(FL_CE_N_O), .FL_WE_N_O(FL_WE_N_O), .FL_OE_N_O(FL_OE_N_O),
    .FL_BYTE_N_O(FL_BYTE_N_O), .FL_ACC_O(FL_ACC_O), .FL_RESET_N_O(FL_RESET_N_O), .FL_RY_I(FL_RY_I));
`default_nettype wire

// File: verif/nfc_host_tb.sv
// self-checking testbench of the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "nfc_regs.svh"
module nfc_host_tb;
    typedef logic [61:0] nfc_row_type;
    localparam logic [15:0] ID = 16'h5a3c;
    logic clk, rst, wr, rd, dq_oe_n, ce_n, we_n, oe_n, byte_n, acc, reset_n, ry;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, s;
    logic [21:0] fl_addr;
    logic [15:0] fl_dq, flash_dq, wire_dq;
    int failures = 0;
    int n_tests = 0;
    nfc_row_type rows [19];
    assign wire_dq = dq_oe_n ? flash_dq : fl_dq;
    nfc_host u_nfc_host (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .FL_ADDR_O(fl_addr), .FL_DQ_O(fl_dq), .FL_DQ_OE_N_O(dq_oe_n), .FL_DQ_I(wire_dq),
        .FL_CE_N_O(ce_n), .FL_WE_N_O(we_n), .FL_OE_N_O(oe_n), .FL_BYTE_N_O(byte_n), .FL_ACC_O(acc),
        .FL_RESET_N_O(reset_n), .FL_RY_I(ry));
    nfc_flash_mdl #(.IDENT_WORD(ID)) u_flash (.addr_i(fl_addr), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .acc_i(acc), .reset_n_i(reset_n), .dq_i(wire_dq), .dq_o(flash_dq), .ry_o(ry));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================================
    // bus tasks
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && n < 600) begin
            rd_reg(`NFC_REG_STATUS, s);
            n++;
        end
        check("busy", {31'h0, s[0]}, 32'h0);
    endtask
    task automatic run_op(input logic [3:0] code, input logic [21:0] a, input logic [15:0] d);
        wr_reg(`NFC_REG_ADDR, {10'h0, a});
        wr_reg(`NFC_REG_WDATA, {16'h0, d});
        wr_reg(`NFC_REG_CMD, {28'h0, code});
        wait_idle();
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        int cyc;
        cyc = 0;
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc == 40000) begin
                failures++;
                finish_test();
            end
        end
    end
    // ==========================================================
    // main sequence: {op, address, data, err/ident/secured/bypass, read word}
    initial begin
        {rst, wr, rd, addr, wdata} = {3'b100, 4'h0, 32'h0};
        rows = '{{4'h1, 22'h0, 16'h0, 4'h0, 16'h0}, {4'h2, 22'h0, 16'h0, 4'h4, 16'h0},
            {4'h0, 22'h10, 16'h0, 4'h4, ID}, {4'h1, 22'h0, 16'h0, 4'h0, 16'h0},
            {4'h5, 22'h10, 16'h0f0f, 4'h0, 16'h0}, {4'h0, 22'h10, 16'h0, 4'h0, 16'h0f0f},
            {4'h5, 22'h10, 16'h00ff, 4'h0, 16'h0}, {4'h0, 22'h10, 16'h0, 4'h0, 16'h000f},
            {4'h3, 22'h0, 16'h0, 4'h2, 16'h0}, {4'h0, 22'h10, 16'h0, 4'h2, 16'hffff},
            {4'h6, 22'h0, 16'h0, 4'ha, 16'h0}, {4'h4, 22'h0, 16'h0, 4'h8, 16'h0},
            {4'h1, 22'h0, 16'h0, 4'h0, 16'h0}, {4'h6, 22'h0, 16'h0, 4'h1, 16'h0},
            {4'h7, 22'h20, 16'h1234, 4'h1, 16'h0}, {4'h2, 22'h0, 16'h0, 4'h9, 16'h0},
            {4'h8, 22'h0, 16'h0, 4'h8, 16'h0}, {4'h0, 22'h20, 16'h0, 4'h8, 16'h1234},
            {4'h1, 22'h0, 16'h0, 4'h0, 16'h0}};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`NFC_REG_STATUS, s);
        check("idle status", {25'h0, s[6:0]}, 32'h2);
        check("idle strobes", {29'h0, ce_n, we_n, dq_oe_n}, 32'h7);
        for (int i = 0; i < 19; i++) begin
            run_op(rows[i][61:58], rows[i][57:36], rows[i][35:20]);
            rd_reg(`NFC_REG_STATUS, s);
            check("mode bits", {28'h0, s[6:3]}, {28'h0, rows[i][19:16]});
            if (rows[i][61:58] == 4'h0) begin
                rd_reg(`NFC_REG_RDATA, s);
                check("read word", s, {16'h0, rows[i][15:0]});
            end
        end
        // command written while programming is dropped
        wr_reg(`NFC_REG_ADDR, 32'h40);
        wr_reg(`NFC_REG_WDATA, 32'h5555);
        wr_reg(`NFC_REG_CMD, 32'h5);
        wr_reg(`NFC_REG_CMD, 32'h2);
        wait_idle();
        run_op(4'h0, 22'h40, 16'h0);
        check("ident after busy", {30'h0, s[6:5]}, 32'h0);
        rd_reg(`NFC_REG_RDATA, s);
        check("busy program", s, 32'h5555);
        // failed program keeps ready low until reset
        u_flash.fail_q = 1'b1;
        run_op(4'h5, 22'h30, 16'h00aa);
        check("timeout status", {30'h0, s[2:1]}, 32'h2);
        u_flash.fail_q = 1'b0;
        run_op(4'h1, 22'h0, 16'h0);
        check("after reset", {30'h0, s[2:1]}, 32'h1);
        // width and accelerate pins, unmapped write ignored
        wr_reg(`NFC_REG_CTRL, 32'h1);
        wr_reg(4'hf, 32'h0);
        rd_reg(`NFC_REG_CTRL, s);
        check("ctrl", {30'h0, s[1:0]}, 32'h1);
        check("byte pin", {31'h0, byte_n}, 32'h0);
        run_op(4'h3, 22'h0, 16'h0);
        wr_reg(`NFC_REG_CTRL, 32'h3);
        repeat (2) @(negedge clk);
        check("acc secured", {31'h0, acc}, 32'h0);
        wr_reg(`NFC_REG_CTRL, 32'h1);
        run_op(4'h4, 22'h0, 16'h0);
        wr_reg(`NFC_REG_CTRL, 32'h2);
        repeat (2) @(negedge clk);
        check("acc pin", {31'h0, acc}, 32'h1);
        wr_reg(`NFC_REG_CTRL, 32'h0);
        run_op(4'h9, 22'h40, 16'h0);
        check("suspend", {25'h0, s[6:0]}, 32'h2);
        finish_test();
    end
endmodule
`default_nettype wire
